// >>> rtl/plc_loop_control.sv
// Functional notes
// - unused register bits read zero, ignore writes
// - control bit 6 always reads one
// - source select zero: enable bit picks clock
// - source select one: enable bit ignored
// - control bit 3 drives loop reset
// - control bit 1 drives loop power-down
// - enable off: clocks from reference, bypass
// - enable on: clocks from loop output
// - multiplier equals field value plus one
// - pre-divider enable gates its output
// - pre-divider divides by ratio plus one
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
module plc_loop_control
    import plc_pkg::*;
#(
    parameter logic [31:0] CTL_RESET_VAL = plc_pkg::LOOP_CONTROL_RESET,
    parameter logic [31:0] MULT_RESET_VAL = plc_pkg::LOOP_MULTIPLIER_RESET,
    parameter logic [31:0] REFERENCE_PREDIVIDER_RESET_VAL = plc_pkg::REFERENCE_PREDIVIDER_RESET
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RSTN,
    // register port
    input wire plc_pkg::plc_req_t REQ,
    output logic [31:0] RDATA,
    // alternate enable source, asynchronous pin
    input wire logic EXT_LOOP_ENABLE,
    // loop core controls
    output logic LOOP_RESET,
    output logic LOOP_POWER_DOWN,
    output logic [6:0] LOOP_MULTIPLY,
    output logic REFERENCE_PREDIVIDER_TICK,
    // system clock source enables
    output logic BYPASS_CLK_EN,
    output logic LOOP_CLK_EN
);
    import plc_pkg::*;

    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    logic source_select_ff;
    logic output_select_ff;
    logic reset_ctl_ff;
    logic power_down_ff;
    logic [MULT_W-1:0] multiplier_ff;
    logic predivider_enable_ff;
    logic [RATIO_W-1:0] ratio_ff;
    logic [31:0] rdata_ff;

    logic wr_ctl;
    logic wr_mult;
    logic wr_reference_predivider;

    assign wr_ctl = REQ.wr && REQ.addr == LOOP_CONTROL_OFS;
    assign wr_mult = REQ.wr && REQ.addr == LOOP_MULTIPLIER_OFS;
    assign wr_reference_predivider = REQ.wr && REQ.addr == REFERENCE_PREDIVIDER_OFS;

    // bits 7 and 4 are not stored, so a careless write of one there is harmless
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            source_select_ff <= CTL_RESET_VAL[CTL_SOURCE_SELECT_BIT];
            output_select_ff <= CTL_RESET_VAL[CTL_OUTPUT_SELECT_BIT];
            reset_ctl_ff <= CTL_RESET_VAL[CTL_RESET_BIT];
            power_down_ff <= CTL_RESET_VAL[CTL_POWER_DOWN_BIT];
        end else if (wr_ctl) begin
            source_select_ff <= REQ.wdata[CTL_SOURCE_SELECT_BIT];
            output_select_ff <= REQ.wdata[CTL_OUTPUT_SELECT_BIT];
            reset_ctl_ff <= REQ.wdata[CTL_RESET_BIT];
            power_down_ff <= REQ.wdata[CTL_POWER_DOWN_BIT];
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            multiplier_ff <= MULT_RESET_VAL[MULT_W-1:0];
        end else if (wr_mult) begin
            multiplier_ff <= REQ.wdata[MULT_W-1:0];
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            predivider_enable_ff <= REFERENCE_PREDIVIDER_RESET_VAL[REFERENCE_PREDIVIDER_ENABLE_BIT];
            ratio_ff <= REFERENCE_PREDIVIDER_RESET_VAL[RATIO_W-1:0];
        end else if (wr_reference_predivider) begin
            predivider_enable_ff <= REQ.wdata[REFERENCE_PREDIVIDER_ENABLE_BIT];
            ratio_ff <= REQ.wdata[RATIO_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    logic [31:0] ctl_view;
    logic [31:0] mult_view;
    logic [31:0] reference_predivider_view;
    logic [31:0] nxt_rdata;

    always_comb begin
        ctl_view = 32'h0000_0000;
        ctl_view[CTL_READS_ONE_BIT] = 1'b1;
        ctl_view[CTL_SOURCE_SELECT_BIT] = source_select_ff;
        ctl_view[CTL_RESET_BIT] = reset_ctl_ff;
        ctl_view[CTL_POWER_DOWN_BIT] = power_down_ff;
        ctl_view[CTL_OUTPUT_SELECT_BIT] = output_select_ff;
        mult_view = {{(32-MULT_W){1'b0}}, multiplier_ff};
        reference_predivider_view = 32'h0000_0000;
        reference_predivider_view[REFERENCE_PREDIVIDER_ENABLE_BIT] = predivider_enable_ff;
        reference_predivider_view[RATIO_W-1:0] = ratio_ff;
    end

    // unmapped addresses answer zero
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (REQ.rd) begin
            unique case (REQ.addr)
                LOOP_CONTROL_OFS: nxt_rdata = ctl_view;
                LOOP_MULTIPLIER_OFS: nxt_rdata = mult_view;
                REFERENCE_PREDIVIDER_OFS: nxt_rdata = reference_predivider_view;
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            rdata_ff <= 32'h0000_0000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign RDATA = rdata_ff;

    // ----------------------------------------------------------------
    // enable source
    // ----------------------------------------------------------------
    logic ext_meta_ff;
    logic ext_sync_ff;
    logic effective_enable;

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            ext_meta_ff <= 1'b0;
            ext_sync_ff <= 1'b0;
        end else begin
            ext_meta_ff <= EXT_LOOP_ENABLE;
            ext_sync_ff <= ext_meta_ff;
        end
    end

    // select one hands the choice to the pin and never looks at the register bit
    assign effective_enable = source_select_ff ? ext_sync_ff : output_select_ff;

    // ----------------------------------------------------------------
    // source switch sequencer
    // ----------------------------------------------------------------
    // break before make: both enables low for the gap, so no runt pulse reaches the clocks
    plc_sel_state_t state_ff;
    plc_sel_state_t nxt_state;
    logic [2:0] gap_ff;
    logic [2:0] nxt_gap;
    logic byp_en_ff;
    logic loop_en_ff;

    localparam logic [2:0] GAP_LAST = 3'(SWITCH_GAP_CYC - 1);

    always_comb begin
        nxt_state = state_ff;
        nxt_gap = gap_ff;
        unique case (state_ff)
            PLC_BYPASS: begin
                if (effective_enable) begin
                    nxt_state = PLC_TO_LOOP;
                    nxt_gap = 3'h0;
                end
            end
            PLC_TO_LOOP: begin
                if (!effective_enable) begin
                    nxt_state = PLC_TO_BYPASS;
                    nxt_gap = 3'h0;
                end else if (gap_ff == GAP_LAST) begin
                    nxt_state = PLC_LOOP;
                end else begin
                    nxt_gap = gap_ff + 3'h1;
                end
            end
            PLC_LOOP: begin
                if (!effective_enable) begin
                    nxt_state = PLC_TO_BYPASS;
                    nxt_gap = 3'h0;
                end
            end
            PLC_TO_BYPASS: begin
                if (gap_ff == GAP_LAST) begin
                    nxt_state = PLC_BYPASS;
                end else begin
                    nxt_gap = gap_ff + 3'h1;
                end
            end
        endcase
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            state_ff <= PLC_BYPASS;
            gap_ff <= 3'h0;
        end else begin
            state_ff <= nxt_state;
            gap_ff <= nxt_gap;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            byp_en_ff <= 1'b0;
            loop_en_ff <= 1'b0;
        end else begin
            byp_en_ff <= nxt_state == PLC_BYPASS;
            loop_en_ff <= nxt_state == PLC_LOOP;
        end
    end

    assign BYPASS_CLK_EN = byp_en_ff;
    assign LOOP_CLK_EN = loop_en_ff;

    // ----------------------------------------------------------------
    // loop core controls
    // ----------------------------------------------------------------
    logic [6:0] multiply_ff;

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            multiply_ff <= 7'h01;
        end else begin
            multiply_ff <= {1'b0, multiplier_ff} + 7'h01;
        end
    end

    assign LOOP_MULTIPLY = multiply_ff;
    assign LOOP_RESET = reset_ctl_ff;
    assign LOOP_POWER_DOWN = power_down_ff;

    // ----------------------------------------------------------------
    // reference pre-divider
    // ----------------------------------------------------------------
    plc_predivider #(
        .RATIO_W(RATIO_W)
    ) u_predivider (
        .clock(CLOCK),
        .rstn(RSTN),
        .enable(predivider_enable_ff),
        .ratio(ratio_ff),
        .tick_ff(REFERENCE_PREDIVIDER_TICK)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_ctl_reserved_zero: assert property (@(posedge CLOCK) disable iff (!RSTN)
        REQ.rd && REQ.addr == LOOP_CONTROL_OFS |=> RDATA[31:7] == 25'h0 && RDATA[4] == 1'b0 && RDATA[2] == 1'b0)
        else $error("reserved control bits read nonzero");

    a_mult_reserved_zero: assert property (@(posedge CLOCK) disable iff (!RSTN)
        REQ.rd && REQ.addr == LOOP_MULTIPLIER_OFS |=> RDATA[31:6] == 26'h0)
        else $error("reserved multiplier bits read nonzero");

    a_ctl_bit_one: assert property (@(posedge CLOCK) disable iff (!RSTN)
        REQ.rd && REQ.addr == LOOP_CONTROL_OFS |=> RDATA[6] == 1'b1)
        else $error("control bit six does not read one");

    a_register_selects: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (!source_select_ff && output_select_ff)[*8] |-> LOOP_CLK_EN && !BYPASS_CLK_EN)
        else $error("enable bit does not select loop output");

    a_source_ignores_bit: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (source_select_ff && !ext_sync_ff)[*8] |-> BYPASS_CLK_EN)
        else $error("enable bit acted while source select is one");

    a_reset_follows_write: assert property (@(posedge CLOCK) disable iff (!RSTN)
        wr_ctl |=> LOOP_RESET == $past(REQ.wdata[CTL_RESET_BIT]))
        else $error("loop reset does not follow control write");

    a_pdown_follows_write: assert property (@(posedge CLOCK) disable iff (!RSTN)
        wr_ctl |=> LOOP_POWER_DOWN == $past(REQ.wdata[CTL_POWER_DOWN_BIT]))
        else $error("power-down does not follow control write");

    a_bypass_when_off: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (!effective_enable)[*7] |-> BYPASS_CLK_EN && !LOOP_CLK_EN)
        else $error("bypass not reached with enable off");

    a_loop_when_on: assert property (@(posedge CLOCK) disable iff (!RSTN)
        $rose(effective_enable) ##1 effective_enable[*5] |=> LOOP_CLK_EN)
        else $error("loop output not selected with enable on");

    a_multiply_value: assert property (@(posedge CLOCK) disable iff (!RSTN)
        wr_mult ##1 !wr_mult |=> LOOP_MULTIPLY == {1'b0, $past(REQ.wdata[5:0], 2)} + 7'h01)
        else $error("multiply factor is not field plus one");

    a_source_exclusive: assert property (@(posedge CLOCK) disable iff (!RSTN)
        !(BYPASS_CLK_EN && LOOP_CLK_EN))
        else $error("both clock sources enabled together");

    a_switch_gap: assert property (@(posedge CLOCK) disable iff (!RSTN)
        $fell(BYPASS_CLK_EN) |-> (!LOOP_CLK_EN)[*4])
        else $error("source switch gap too short");

    c_enter_loop: cover property (@(posedge CLOCK) disable iff (!RSTN) $rose(LOOP_CLK_EN));
    c_back_to_bypass: cover property (@(posedge CLOCK) disable iff (!RSTN)
        $fell(LOOP_CLK_EN) ##[1:8] BYPASS_CLK_EN);
    c_pin_source: cover property (@(posedge CLOCK) disable iff (!RSTN)
        source_select_ff && ext_sync_ff && LOOP_CLK_EN);
endmodule

// >>> rtl/plc_pkg.sv
// ----------------------------------------------------------------
// loop control package
// ----------------------------------------------------------------
package plc_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [11:0] LOOP_CONTROL_OFS = 12'h100;
    localparam logic [11:0] LOOP_MULTIPLIER_OFS = 12'h110;
    localparam logic [11:0] REFERENCE_PREDIVIDER_OFS = 12'h114;

    // ----------------------------------------------------------------
    // field positions and widths
    // ----------------------------------------------------------------
    localparam int CTL_OUTPUT_SELECT_BIT = 0;
    localparam int CTL_POWER_DOWN_BIT = 1;
    localparam int CTL_RESET_BIT = 3;
    localparam int CTL_SOURCE_SELECT_BIT = 5;
    localparam int CTL_READS_ONE_BIT = 6;
    localparam int REFERENCE_PREDIVIDER_ENABLE_BIT = 15;
    localparam int MULT_W = 6;
    localparam int RATIO_W = 5;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] LOOP_CONTROL_RESET = 32'h0000_0048;
    localparam logic [31:0] LOOP_MULTIPLIER_RESET = 32'h0000_0000;
    localparam logic [31:0] REFERENCE_PREDIVIDER_RESET = 32'h0000_8000;

    // ----------------------------------------------------------------
    // timing counts
    // ----------------------------------------------------------------
    localparam int SWITCH_GAP_CYC = 4;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } plc_req_t;

    typedef enum logic [1:0] {
        PLC_BYPASS = 2'b00,
        PLC_TO_LOOP = 2'b01,
        PLC_LOOP = 2'b11,
        PLC_TO_BYPASS = 2'b10
    } plc_sel_state_t;

endpackage

// >>> rtl/plc_predivider.sv
`timescale 1ns/1ps
module plc_predivider #(
    parameter int RATIO_W = 5
) (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // control
    input wire logic enable,
    input wire logic [RATIO_W-1:0] ratio,
    // divided tick
    output logic tick_ff
);
    logic [RATIO_W-1:0] cnt_ff;

    // ----------------------------------------------------------------
    // divider counter
    // ----------------------------------------------------------------
    // a tick every ratio+1 cycles; ">=" keeps a shrinking ratio from overrunning
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cnt_ff <= '0;
        end else if (!enable) begin
            cnt_ff <= '0;
        end else if (cnt_ff >= ratio) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= enable && (cnt_ff >= ratio);
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [6:0] since_ff;
    logic steady_ff;
    logic [RATIO_W-1:0] prev_ratio_ff;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            since_ff <= '0;
            steady_ff <= 1'b0;
            prev_ratio_ff <= '0;
        end else begin
            prev_ratio_ff <= ratio;
            since_ff <= tick_ff ? 7'h00 : (since_ff == 7'h7f ? since_ff : since_ff + 1'b1);
            if (!enable || ratio != prev_ratio_ff) begin
                steady_ff <= 1'b0;
            end else if (tick_ff) begin
                steady_ff <= 1'b1;
            end
        end
    end

    a_tick_period: assert property (@(posedge clock) disable iff (!rstn)
        tick_ff && steady_ff && enable && ratio == prev_ratio_ff |-> since_ff == {2'b00, ratio})
        else $error("pre-divider tick period differs from ratio plus one");

    a_no_tick_off: assert property (@(posedge clock) disable iff (!rstn)
        !enable |=> !tick_ff)
        else $error("pre-divider ticks while disabled");

    c_max_ratio: cover property (@(posedge clock) disable iff (!rstn)
        tick_ff && steady_ff && ratio == 5'h1f);
endmodule

// >>> verification/plc_core_model.sv
`timescale 1ns/1ps
module plc_core_model #(
    parameter int LOCK_CYC = 16
) (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // loop controls from the block
    input wire logic loop_reset,
    input wire logic power_down,
    input wire logic loop_clk_en,
    input wire logic [6:0] multiply,
    // status seen by the bench
    output logic locked,
    output logic misuse_ff
);
    logic [7:0] lock_cnt_ff;
    logic [6:0] mult_seen_ff;

    // ----------------------------------------------------------------
    // lock timer
    // ----------------------------------------------------------------
    // relock starts over whenever reset or power-down is applied
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            lock_cnt_ff <= 8'h00;
        end else if (loop_reset || power_down) begin
            lock_cnt_ff <= 8'h00;
        end else if (lock_cnt_ff < LOCK_CYC[7:0]) begin
            lock_cnt_ff <= lock_cnt_ff + 8'h01;
        end
    end
    assign locked = (lock_cnt_ff == LOCK_CYC[7:0]);

    // ----------------------------------------------------------------
    // misuse watch
    // ----------------------------------------------------------------
    // a real core would lose lock or glitch the clocks, so flag it
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            // matches the factor the block shows in reset
            mult_seen_ff <= 7'h01;
            misuse_ff <= 1'b0;
        end else begin
            mult_seen_ff <= multiply;
            if (multiply != mult_seen_ff && (!loop_reset || loop_clk_en)) begin
                misuse_ff <= 1'b1;
            end
            if ((loop_reset || power_down) && loop_clk_en) begin
                misuse_ff <= 1'b1;
            end
        end
    end
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import plc_pkg::*;

    logic CLOCK;
    logic RSTN;
    plc_req_t REQ;
    logic EXT_LOOP_ENABLE;
    logic [31:0] RDATA;
    logic LOOP_RESET;
    logic LOOP_POWER_DOWN;
    logic [6:0] LOOP_MULTIPLY;
    logic REFERENCE_PREDIVIDER_TICK;
    logic BYPASS_CLK_EN;
    logic LOOP_CLK_EN;
    logic locked;
    logic misuse;
    int n_fail = 0;
    int cmp_count = 0;

    plc_loop_control dut (.CLOCK(CLOCK), .RSTN(RSTN), .REQ(REQ), .RDATA(RDATA),
        .EXT_LOOP_ENABLE(EXT_LOOP_ENABLE), .LOOP_RESET(LOOP_RESET), .LOOP_POWER_DOWN(LOOP_POWER_DOWN),
        .LOOP_MULTIPLY(LOOP_MULTIPLY), .REFERENCE_PREDIVIDER_TICK(REFERENCE_PREDIVIDER_TICK), .BYPASS_CLK_EN(BYPASS_CLK_EN),
        .LOOP_CLK_EN(LOOP_CLK_EN));

    plc_core_model core_model (.clock(CLOCK), .rstn(RSTN), .loop_reset(LOOP_RESET),
        .power_down(LOOP_POWER_DOWN), .loop_clk_en(LOOP_CLK_EN), .multiply(LOOP_MULTIPLY),
        .locked(locked), .misuse_ff(misuse));

    // ----------------------------------------------------------------
    // clock and watchdog
    // ----------------------------------------------------------------
    initial begin
        CLOCK = 1'b0;
        forever #2.5 CLOCK = ~CLOCK;
    end

    // whole run needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge CLOCK);
        n_fail++;
        $display("Error watchdog expired");
        tally_and_finish();
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic do_reset();
        @(posedge CLOCK);
        RSTN <= 1'b0;
        repeat (2) @(posedge CLOCK);
        RSTN <= 1'b1;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge CLOCK);
        REQ <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge CLOCK);
        REQ <= '0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
        @(posedge CLOCK);
        REQ <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
        @(posedge CLOCK);
        REQ <= '0;
        #1 check(nm, exp, RDATA);
    endtask

    task automatic step(input int n);
        repeat (n) begin
            @(posedge CLOCK);
            #1;
        end
    endtask

    // break-before-make: never both enables, at least the gap with both low
    task automatic wait_switch(input logic to_loop);
        int n;
        int gap;
        int both;
        n = 0;
        gap = 0;
        both = 0;
        #1;
        while ((to_loop ? LOOP_CLK_EN : BYPASS_CLK_EN) !== 1'b1 && n < 30) begin
            step(1);
            n++;
            if (BYPASS_CLK_EN === 1'b1 && LOOP_CLK_EN === 1'b1) both++;
            if (BYPASS_CLK_EN === 1'b0 && LOOP_CLK_EN === 1'b0) gap++;
        end
        check("switch_reached", 32'h1, {31'h0, n < 30});
        check("switch_overlap", 32'h0, both);
        check("switch_gap", 32'h1, {31'h0, gap >= SWITCH_GAP_CYC});
    endtask

    task automatic tick_period(input logic [4:0] r);
        int n;
        n = 0;
        #1;
        while (REFERENCE_PREDIVIDER_TICK !== 1'b1 && n < 40) begin
            step(1);
            n++;
        end
        repeat (2) begin
            n = 0;
            do begin
                step(1);
                n++;
            end while (REFERENCE_PREDIVIDER_TICK !== 1'b1 && n < 40);
        end
        check("tick_period", {27'h0, r} + 32'h1, n);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_values();
        step(1);
        check("bypass_after_reset", 32'h1, {31'h0, BYPASS_CLK_EN});
        check("reset_pin", 32'h1, {31'h0, LOOP_RESET});
        rd_chk("ctl_reset", LOOP_CONTROL_OFS, 32'h0000_0048);
        step(1);
        check("rdata_idle", 32'h0, RDATA);
        rd_chk("mult_reset", LOOP_MULTIPLIER_OFS, 32'h0000_0000);
        rd_chk("reference_predivider_reset", REFERENCE_PREDIVIDER_OFS, 32'h0000_8000);
    endtask

    task automatic t_reserved();
        wr(LOOP_CONTROL_OFS, 32'hffff_ff6f);
        rd_chk("ctl_reserved", LOOP_CONTROL_OFS, 32'h0000_006b);
        wr(LOOP_CONTROL_OFS, 32'h0000_0008);
        rd_chk("ctl_bit6", LOOP_CONTROL_OFS, 32'h0000_0048);
        wr(LOOP_MULTIPLIER_OFS, 32'hffff_ffff);
        rd_chk("mult_reserved", LOOP_MULTIPLIER_OFS, 32'h0000_003f);
        check("multiply_max", 32'd64, {25'h0, LOOP_MULTIPLY});
        wr(REFERENCE_PREDIVIDER_OFS, 32'hffff_ffff);
        rd_chk("reference_predivider_reserved", REFERENCE_PREDIVIDER_OFS, 32'h0000_801f);
        wr(12'h118, 32'hffff_ffff);
        rd_chk("unmapped", 12'h118, 32'h0000_0000);
        rd_chk("ctl_untouched", LOOP_CONTROL_OFS, 32'h0000_0048);
    endtask

    task automatic t_mult();
        logic [5:0] vals[3] = '{6'h00, 6'h3f, 6'h15};
        foreach (vals[i]) begin
            wr(LOOP_MULTIPLIER_OFS, {26'h0, vals[i]});
            step(2);
            check("multiply", {26'h0, vals[i]} + 32'h1, {25'h0, LOOP_MULTIPLY});
        end
    endtask

    task automatic t_ctl_pins();
        wr(LOOP_CONTROL_OFS, 32'h0000_000a);
        step(1);
        check("pd_on", 32'h1, {31'h0, LOOP_POWER_DOWN});
        check("rst_on", 32'h1, {31'h0, LOOP_RESET});
        wr(LOOP_CONTROL_OFS, 32'h0000_0008);
        step(1);
        check("pd_off", 32'h0, {31'h0, LOOP_POWER_DOWN});
        t_mult();
        wr(LOOP_CONTROL_OFS, 32'h0000_0000);
        step(1);
        check("rst_off", 32'h0, {31'h0, LOOP_RESET});
        step(20);
        check("core_locked", 32'h1, {31'h0, locked});
    endtask

    task automatic t_switch();
        wr(LOOP_CONTROL_OFS, 32'h0000_0001);
        wait_switch(1'b1);
        wr(LOOP_CONTROL_OFS, 32'h0000_0020);
        wait_switch(1'b0);
        @(posedge CLOCK);
        EXT_LOOP_ENABLE <= 1'b1;
        wait_switch(1'b1);
        wr(LOOP_CONTROL_OFS, 32'h0000_0021);
        step(10);
        check("pin_holds_loop", 32'h1, {31'h0, LOOP_CLK_EN});
        @(posedge CLOCK);
        EXT_LOOP_ENABLE <= 1'b0;
        wait_switch(1'b0);
        wr(LOOP_CONTROL_OFS, 32'h0000_0000);
        step(10);
        check("bit_holds_bypass", 32'h1, {31'h0, BYPASS_CLK_EN});
        step(4);
        wr(LOOP_CONTROL_OFS, 32'h0000_0008);
    endtask

    task automatic t_reference_predivider();
        int n;
        logic [4:0] ratios[3] = '{5'h00, 5'h02, 5'h1f};
        foreach (ratios[i]) begin
            wr(REFERENCE_PREDIVIDER_OFS, {16'h0, 1'b1, 10'h0, ratios[i]});
            tick_period(ratios[i]);
        end
        wr(REFERENCE_PREDIVIDER_OFS, 32'h0000_0000);
        step(2);
        n = 0;
        repeat (70) begin
            step(1);
            if (REFERENCE_PREDIVIDER_TICK !== 1'b0) n++;
        end
        check("tick_disabled", 32'h0, n);
    endtask

    task automatic t_midrun_reset();
        @(posedge CLOCK);
        RSTN <= 1'b0;
        step(1);
        check("rst_clk_en", 32'h0, {30'h0, BYPASS_CLK_EN, LOOP_CLK_EN});
        @(posedge CLOCK);
        RSTN <= 1'b1;
        step(1);
        check("bypass_after_midrun", 32'h1, {31'h0, BYPASS_CLK_EN});
        rd_chk("ctl_after_reset", LOOP_CONTROL_OFS, 32'h0000_0048);
        check("multiply_after_reset", 32'h1, {25'h0, LOOP_MULTIPLY});
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        RSTN = 1'b0;
        REQ = '0;
        EXT_LOOP_ENABLE = 1'b0;
        do_reset();
        t_reset_values();
        t_reserved();
        t_ctl_pins();
        t_switch();
        t_reference_predivider();
        // the model's flag is cleared by reset, so look before the mid-run one
        check("core_misuse_early", 32'h0, {31'h0, misuse});
        t_midrun_reset();
        check("core_misuse", 32'h0, {31'h0, misuse});
        tally_and_finish();
    end
endmodule
